// >>> src/fdi_drive.sv
module fdi_drive #(
  parameter int unsigned POWER_SAVE_CYC   = fdi_pkg::POWER_SAVE_CYC,
  parameter int unsigned UP_TO_SPEED_CYC  = fdi_pkg::UP_TO_SPEED_CYC,
  parameter int unsigned RESTORE_STEP_CYC = fdi_pkg::RESTORE_STEP_CYC
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire fdi_pkg::fdi_host_in_t  host_in,
  input  wire fdi_pkg::fdi_mech_in_t  mech_in,
  input  wire fdi_pkg::fdi_jumper_t   jumper_in,
  output fdi_pkg::fdi_host_out_t      host_out,
  output fdi_pkg::fdi_host_out_t      host_oe,
  output fdi_pkg::fdi_mech_out_t      mech_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  fdi_pkg::fdi_host_in_t host_m, host_s;
  fdi_pkg::fdi_mech_in_t mech_m, mech_s;
  fdi_pkg::fdi_jumper_t  jmp_m, jmp_s, cfg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_m <= '1;
      host_s <= '1;
      mech_m <= '0;
      mech_s <= '0;
      jmp_m  <= '0;
      jmp_s  <= '0;
    end else begin
      host_m <= host_in;
      host_s <= host_m;
      mech_m <= mech_in;
      mech_s <= mech_m;
      jmp_m  <= jumper_in;
      jmp_s  <= jmp_m;
    end
  end

  // ----------------------------------------------------------------
  // Registers and shared decode
  // ----------------------------------------------------------------
  fdi_pkg::fdi_state_t state;
  logic [31:0] ctrl;
  logic [31:0] steps;
  logic [6:0]  track;
  logic        restore_req;
  logic        hmp_d, fwp_d, flux_d, trk0_d, idx_d;
  logic [7:0]  low_cnt;
  logic        dir_lat;
  logic [31:0] ps_cnt;
  logic [31:0] spin_cnt;
  logic        index_seen;
  logic [7:0]  rd_cnt;
  logic [31:0] rs_cnt;

  wire selected   = !host_s.unit_choose_line_n && !ctrl[fdi_pkg::CTRL_DESEL_BIT];
  wire spindle_on = !host_s.spindle_request_n;
  wire protect    = mech_s.protect_tab;
  wire at_zero    = (track == 7'd0);
  wire running    = (state == fdi_pkg::ST_RUN);
  wire writing    = selected && !host_s.record_gate_n && !protect;
  wire up_to_speed = spindle_on && (spin_cnt >= UP_TO_SPEED_CYC);

  // Trailing edge of a long enough low pulse
  wire step_edge   = !hmp_d && host_s.head_move_pulse_n;
  wire step_long   = (low_cnt >= 8'(fdi_pkg::STEP_MIN_CYC));
  wire step_inward = !dir_lat;
  wire step_block  = !host_s.record_gate_n
                  || (!step_inward && at_zero)
                  || !selected
                  || (cfg.tpi96 && step_inward && track == fdi_pkg::TRACK_LAST)
                  || (cfg.tpi96 && !mech_s.door_closed);
  wire step_ok     = running && step_edge && step_long && !step_block;
  wire rs_step     = (state == fdi_pkg::ST_SEEK0) && !mech_s.track0_sensor;

  function automatic logic rise(input logic prev, input logic now);
    rise = !prev && now;
  endfunction : rise

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hmp_d  <= 1'b1;
      fwp_d  <= 1'b1;
      flux_d <= 1'b0;
      trk0_d <= 1'b0;
      idx_d  <= 1'b0;
    end else begin
      hmp_d  <= host_s.head_move_pulse_n;
      fwp_d  <= host_s.flux_write_pulses_n;
      flux_d <= mech_s.flux_detect;
      trk0_d <= mech_s.track0_sensor;
      idx_d  <= mech_s.index_hole;
    end
  end

  // ----------------------------------------------------------------
  // Step pulse qualification
  // ----------------------------------------------------------------
  // Width counter saturates so a stuck line cannot wrap into a short pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 8'h00;
    end else if (host_s.head_move_pulse_n) begin
      low_cnt <= 8'h00;
    end else if (!step_long) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_lat <= 1'b1;
    end else if (hmp_d && !host_s.head_move_pulse_n) begin
      dir_lat <= host_s.seek_direction;
    end
  end

  // ----------------------------------------------------------------
  // Configuration capture and restore sequence
  // ----------------------------------------------------------------
  // Synchroniser holds reset values for two edges; capture only after that
  logic [1:0] cfg_age;
  wire        cfg_ready = (cfg_age == 2'd2);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_age <= 2'd0;
    end else if (!cfg_ready) begin
      cfg_age <= cfg_age + 2'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '0;
    end else if (state == fdi_pkg::ST_CFG && cfg_ready) begin
      cfg <= jmp_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= fdi_pkg::ST_CFG;
      rs_cnt <= 32'h0000_0000;
    end else begin
      unique case (state)
        fdi_pkg::ST_CFG: begin
          if (cfg_ready) begin
            state <= jmp_s.tpi96 ? fdi_pkg::ST_SEEK0 : fdi_pkg::ST_RUN;
          end
        end
        fdi_pkg::ST_SEEK0: begin
          if (mech_s.track0_sensor) begin
            state <= fdi_pkg::ST_RUN;
          end else begin
            rs_cnt <= RESTORE_STEP_CYC;
            state  <= fdi_pkg::ST_SETTLE;
          end
        end
        fdi_pkg::ST_SETTLE: begin
          if (rs_cnt <= 32'h0000_0001) begin
            state <= fdi_pkg::ST_SEEK0;
          end else begin
            rs_cnt <= rs_cnt - 32'h0000_0001;
          end
        end
        fdi_pkg::ST_RUN: begin
          if (restore_req) begin
            state <= fdi_pkg::ST_SEEK0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Track counter
  // ----------------------------------------------------------------
  // Cleared on the sensor's rising edge, or on its level in ST_SEEK0, so a lagging
  // sensor after an inward step does not wipe the new count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      track <= 7'd0;
    end else if (step_ok) begin
      track <= step_inward ? track + 7'd1 : track - 7'd1;
    end else if (rise(trk0_d, mech_s.track0_sensor)) begin
      track <= 7'd0;
    end else if (state == fdi_pkg::ST_SEEK0 && mech_s.track0_sensor) begin
      track <= 7'd0;
    end
  end

  // ----------------------------------------------------------------
  // Stepper power save and spindle
  // ----------------------------------------------------------------
  // Counter starts at zero, so spinning up alone never raises power
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_cnt <= 32'h0000_0000;
    end else if (step_ok || rs_step) begin
      ps_cnt <= POWER_SAVE_CYC;
    end else if (ps_cnt != 32'h0000_0000) begin
      ps_cnt <= ps_cnt - 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spin_cnt <= 32'h0000_0000;
    end else if (!spindle_on) begin
      spin_cnt <= 32'h0000_0000;
    end else if (!up_to_speed) begin
      spin_cnt <= spin_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_seen <= 1'b0;
    end else if (!spindle_on || !mech_s.door_closed) begin
      index_seen <= 1'b0;
    end else if (rise(idx_d, mech_s.index_hole)) begin
      index_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read pulse stretcher
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_cnt <= 8'h00;
    end else if (rise(flux_d, mech_s.flux_detect) && selected && !writing) begin
      rd_cnt <= 8'(fdi_pkg::READ_PULSE_CYC);
    end else if (rd_cnt != 8'h00) begin
      rd_cnt <= rd_cnt - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  logic ready;
  always_comb begin
    ready = selected && mech_s.door_closed && spindle_on;
    if (cfg.ready_full) begin
      ready = ready && index_seen && up_to_speed;
    end
    ready = ready && cfg.tpi96;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_out <= '1;
    end else begin
      host_out.revolution_marker_n <= !(selected && (mech_s.index_hole
                                     || (mech_s.hard_sector && mech_s.sector_hole)));
      host_out.home_track_flag_n   <= !(selected && at_zero && running);
      host_out.media_locked_n      <= !(selected && protect);
      host_out.flux_read_pulses_n  <= !(selected && rd_cnt != 8'h00);
      host_out.ready_n             <= !ready;
    end
  end

  // Open collector: pulled low exactly when the level is low
  assign host_oe = ~host_out;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mech_out <= '0;
    end else begin
      mech_out.step_pulse            <= step_ok || rs_step;
      mech_out.step_inward           <= step_ok && step_inward;
      mech_out.stepper_full_power    <= !cfg.tpi96 || step_ok || rs_step
                                        || ps_cnt != 32'h0000_0000;
      mech_out.write_current_en      <= writing;
      mech_out.write_current_reduced <= writing && cfg.tpi96
                                        && track >= fdi_pkg::TRACK_REDUCED;
      mech_out.head_upper            <= !cfg.single_sided && !host_s.head_choice;
      mech_out.read_enable           <= selected && host_s.record_gate_n;
      mech_out.spindle_on            <= spindle_on;
      if (writing && fwp_d && !host_s.flux_write_pulses_n) begin
        mech_out.write_flux_toggle <= !mech_out.write_flux_toggle;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states; unmapped offsets answer with pslverr
  wire apb_acc   = psel && penable;
  wire map_hit   = paddr == fdi_pkg::OFS_CTRL || paddr == fdi_pkg::OFS_STATUS
                || paddr == fdi_pkg::OFS_STEPS;
  wire ctrl_wr   = apb_acc && pwrite && paddr == fdi_pkg::OFS_CTRL;

  assign pready  = 1'b1;
  assign pslverr = apb_acc && !map_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= fdi_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= {31'h0000_0000, pwdata[fdi_pkg::CTRL_DESEL_BIT]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restore_req <= 1'b0;
    end else if (ctrl_wr && pwdata[fdi_pkg::CTRL_RESTO_BIT]) begin
      restore_req <= 1'b1;
    end else if (running) begin
      restore_req <= 1'b0;
    end
  end

  // Write to the step count clears it; a step in the same cycle still counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      steps <= 32'h0000_0000;
    end else if (step_ok) begin
      steps <= (apb_acc && pwrite && paddr == fdi_pkg::OFS_STEPS) ? 32'h0000_0001
                                                                  : steps + 32'h0000_0001;
    end else if (apb_acc && pwrite && paddr == fdi_pkg::OFS_STEPS) begin
      steps <= 32'h0000_0000;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      unique case (paddr)
        fdi_pkg::OFS_CTRL:   prdata = ctrl;
        fdi_pkg::OFS_STATUS: prdata = {17'h00000, up_to_speed, !running,
                                       mech_out.stepper_full_power, protect, writing,
                                       selected, ready, at_zero, track};
        fdi_pkg::OFS_STEPS:  prdata = steps;
        default:             prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_step_inward: assert property (@(posedge pclk) disable iff (!presetn)
    step_ok && step_inward |=> track == $past(track) + 7'd1)
    else $error("inward step did not advance track");

  chk_step_gated: assert property (@(posedge pclk) disable iff (!presetn)
    step_edge && (!host_s.record_gate_n || !selected) |=> !mech_out.step_pulse)
    else $error("step taken while write gated or deselected");

  chk_step_width: assert property (@(posedge pclk) disable iff (!presetn)
    step_ok |-> $past(!host_s.head_move_pulse_n, 40))
    else $error("step accepted from short pulse");

  chk_write_prot: assert property (@(posedge pclk) disable iff (!presetn)
    protect ##1 protect |-> !mech_out.write_current_en)
    else $error("write current on protected media");

  chk_read_gate: assert property (@(posedge pclk) disable iff (!presetn)
    mech_out.write_current_en |-> !mech_out.read_enable)
    else $error("reading while writing");

  chk_read_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(host_out.flux_read_pulses_n) && selected
      |-> ##1 (!host_out.flux_read_pulses_n || !selected)[*8])
    else $error("read pulse too short");

  chk_marker_sect: assert property (@(posedge pclk) disable iff (!presetn)
    selected && !mech_s.hard_sector && !mech_s.index_hole |=> host_out.revolution_marker_n)
    else $error("sector pulse on soft sectored media");

  chk_home_flag: assert property (@(posedge pclk) disable iff (!presetn)
    selected && running && track != 7'd0 |=> host_out.home_track_flag_n)
    else $error("home flag away from track zero");

  chk_cfg_hold: assert property (@(posedge pclk) disable iff (!presetn)
    state != fdi_pkg::ST_CFG |=> $stable(cfg))
    else $error("jumper setting changed after power up");

  chk_power_drop: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.tpi96 && ps_cnt == 32'h0000_0001 && !step_ok && !rs_step
      ##1 !step_ok && !rs_step |=> !mech_out.stepper_full_power)
    else $error("stepper power not reduced after idle time");

  chk_desel_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !selected ##1 !selected |-> host_out == '1)
    else $error("status driven while deselected");

endmodule : fdi_drive

// >>> src/fdi_pkg.sv
package fdi_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned STEP_MIN_NS      = 200;
  localparam int unsigned READ_PULSE_NS    = 1000;
  localparam int unsigned POWER_SAVE_MS    = 50;
  localparam int unsigned UP_TO_SPEED_MS   = 250;
  localparam int unsigned RESTORE_STEP_MS  = 3;
  // Least time rounds up, pulse width is nominal
  localparam int unsigned STEP_MIN_CYC     = (STEP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned READ_PULSE_CYC   = (READ_PULSE_NS * CLK_MHZ) / 1000;
  localparam int unsigned POWER_SAVE_CYC   = POWER_SAVE_MS * CLK_MHZ * 1000;
  localparam int unsigned UP_TO_SPEED_CYC  = UP_TO_SPEED_MS * CLK_MHZ * 1000;
  localparam int unsigned RESTORE_STEP_CYC = RESTORE_STEP_MS * CLK_MHZ * 1000;

  // ----------------------------------------------------------------
  // Track geometry
  // ----------------------------------------------------------------
  localparam logic [6:0] TRACK_LAST    = 7'd79;
  localparam logic [6:0] TRACK_REDUCED = 7'd40;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [7:0]  OFS_STEPS      = 8'h08;
  localparam int unsigned CTRL_DESEL_BIT = 0;
  localparam int unsigned CTRL_RESTO_BIT = 1;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_CFG    = 4'b0001,
    ST_SEEK0  = 4'b0010,
    ST_SETTLE = 4'b0100,
    ST_RUN    = 4'b1000
  } fdi_state_t;

  typedef struct packed {
    logic unit_choose_line_n;
    logic spindle_request_n;
    logic head_move_pulse_n;
    logic seek_direction;
    logic record_gate_n;
    logic head_choice;
    logic flux_write_pulses_n;
  } fdi_host_in_t;

  typedef struct packed {
    logic door_closed;
    logic protect_tab;
    logic hard_sector;
    logic index_hole;
    logic sector_hole;
    logic track0_sensor;
    logic flux_detect;
  } fdi_mech_in_t;

  typedef struct packed {
    logic tpi96;
    logic ready_full;
    logic single_sided;
  } fdi_jumper_t;

  typedef struct packed {
    logic revolution_marker_n;
    logic home_track_flag_n;
    logic media_locked_n;
    logic flux_read_pulses_n;
    logic ready_n;
  } fdi_host_out_t;

  typedef struct packed {
    logic step_pulse;
    logic step_inward;
    logic stepper_full_power;
    logic write_current_en;
    logic write_current_reduced;
    logic write_flux_toggle;
    logic head_upper;
    logic read_enable;
    logic spindle_on;
  } fdi_mech_out_t;

endpackage : fdi_pkg

// >>> bench/fdi_host_model.sv
module fdi_host_model (
  input  wire logic           pclk,
  input  wire logic [3:0]     ctl,
  output fdi_pkg::fdi_host_in_t h
);
  timeunit 1ns;
  timeprecision 1ps;

  initial h = 7'h77;

  // Level pins follow {select_n, spindle_n, write_gate_n, head} at each edge
  always @(posedge pclk) begin
    {h.unit_choose_line_n, h.spindle_request_n, h.record_gate_n, h.head_choice} <= ctl;
  end

  // Direction settles before the pulse and holds past it; spacing is shortened,
  // the drive does not police it
  task automatic step(input logic dir);
    @(posedge pclk) h.seek_direction <= dir;
    repeat (2) @(posedge pclk);
    h.head_move_pulse_n <= 1'b0;
    repeat (48) @(posedge pclk);
    h.head_move_pulse_n <= 1'b1;
    repeat (60) @(posedge pclk);
  endtask : step

  // One FM zero-pattern period (8 us, 125 kHz); no precompensation applied
  task automatic wflux;
    @(posedge pclk) h.flux_write_pulses_n <= 1'b0;
    repeat (800) @(posedge pclk);
    h.flux_write_pulses_n <= 1'b1;
    repeat (800) @(posedge pclk);
  endtask : wflux
endmodule : fdi_host_model

// >>> bench/fdi_drive_bench.sv
module fdi_drive_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                   pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]             paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0, prdata, rv;
  logic                   pready, pslverr, t;
  logic [3:0]             host_ctl = 4'hF;
  fdi_pkg::fdi_host_in_t  hin;
  fdi_pkg::fdi_mech_in_t  mech = '0;
  fdi_pkg::fdi_jumper_t   jmp = 3'b100;
  fdi_pkg::fdi_host_out_t hout, hoe;
  fdi_pkg::fdi_mech_out_t mout;
  int                     n_fail = 0, cmp_count = 0, pos = 0, n, lowc;
  int                     seed = 32'h54DF4E2A;
  logic                   exp_dir[$];
  logic [31:0]            exp_rd[$], exp_mk[$];

  always #2.5 pclk = ~pclk;

  fdi_host_model i_fdi_host_model (.pclk(pclk), .ctl(host_ctl), .h(hin));
  fdi_drive #(.POWER_SAVE_CYC(100), .UP_TO_SPEED_CYC(200), .RESTORE_STEP_CYC(50)) i_fdi_drive (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_in(hin), .mech_in(mech), .jumper_in(jmp), .host_out(hout), .host_oe(hoe),
    .mech_out(mout));
  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_word

  task automatic chk_bit(input logic g, input logic e);
    chk_word({31'h0, g}, {31'h0, e});
  endtask : chk_bit

  task automatic final_report;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  // Head mechanics follow the step pulses, so the zero sensor tracks them
  always @(posedge pclk) begin
    if (mout.step_pulse === 1'b1) begin
      pos = pos + ((mout.step_inward === 1'b1) ? 1 : -1);
      if (exp_dir.size() == 0) chk_bit(1'b1, 1'b0);
      else chk_bit(mout.step_inward, exp_dir.pop_front());
    end
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk_word(prdata & exp_mk.pop_front(), exp_rd.pop_front());
    mech.track0_sensor <= (pos == 0);
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk_bit(pslverr, !(a inside {fdi_pkg::OFS_CTRL, fdi_pkg::OFS_STATUS, fdi_pkg::OFS_STEPS}));
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    exp_rd.push_back(e);
    exp_mk.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #200us;
    n_fail++;
    final_report();
  end

  initial begin
    jmp.single_sided <= 1'($random(seed));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (300) @(posedge pclk);
    host_ctl <= 4'b0011;
    mech.door_closed <= 1'b1;
    repeat (20) @(posedge pclk);
    chk_bit(mout.spindle_on, 1'b1);
    chk_bit(hout.ready_n, 1'b0);
    chk_bit(hout.home_track_flag_n, 1'b0);
    $display("test select done");
    n = 38 + int'($unsigned($random(seed)) % 4);
    repeat (n) begin
      exp_dir.push_back(1'b1);
      i_fdi_host_model.step(1'b0);
    end
    rd(fdi_pkg::OFS_STATUS, 32'hFF, 32'(n));
    chk_bit(hout.home_track_flag_n, 1'b1);
    host_ctl <= 4'b0000;
    repeat (10) @(posedge pclk);
    chk_bit(mout.write_current_en, 1'b1);
    chk_bit(mout.read_enable, 1'b0);
    chk_bit(mout.head_upper, !jmp.single_sided);
    chk_bit(mout.write_current_reduced, n >= 40);
    t = mout.write_flux_toggle;
    i_fdi_host_model.wflux();
    chk_bit(mout.write_flux_toggle, ~t);
    i_fdi_host_model.step(1'b1);
    mech.protect_tab <= 1'b1;
    repeat (10) @(posedge pclk);
    chk_bit(mout.write_current_en, 1'b0);
    chk_bit(hout.media_locked_n, 1'b0);
    mech.protect_tab <= 1'b0;
    host_ctl <= 4'b0011;
    $display("test write done");
    repeat (n) begin
      exp_dir.push_back(1'b0);
      i_fdi_host_model.step(1'b1);
    end
    i_fdi_host_model.step(1'b1);
    mech.door_closed <= 1'b0;
    i_fdi_host_model.step(1'b0);
    chk_bit(hout.ready_n, 1'b1);
    mech.door_closed <= 1'b1;
    host_ctl <= 4'b1011;
    i_fdi_host_model.step(1'b0);
    chk_bit(hout.home_track_flag_n, 1'b1);
    host_ctl <= 4'b0011;
    rd(fdi_pkg::OFS_STEPS, 32'hFFFF_FFFF, 32'(2 * n));
    rd(fdi_pkg::OFS_STATUS, 32'hFF, 32'h80);
    chk_bit(mout.stepper_full_power, 1'b0);
    $display("test steps done");
    mech.flux_detect <= 1'b1;
    lowc = 0;
    repeat (400) @(posedge pclk) lowc += int'(hout.flux_read_pulses_n === 1'b0);
    mech.flux_detect <= 1'b0;
    chk_word(32'(lowc), 32'(fdi_pkg::READ_PULSE_CYC));
    for (int k = 0; k < 8; k++) begin
      {mech.index_hole, mech.hard_sector, mech.sector_hole} <= 3'(k);
      repeat (6) @(posedge pclk);
      chk_bit(hout.revolution_marker_n, !(k[2] | (k[1] & k[0])));
    end
    $display("test read marker done");
    rv = $random(seed);
    apb(1'b1, fdi_pkg::OFS_STEPS, rv);
    rd(fdi_pkg::OFS_STEPS, 32'hFFFF_FFFF, 32'h0);
    rd(8'h0C, 32'hFFFF_FFFF, 32'h0);
    apb(1'b1, fdi_pkg::OFS_CTRL, rv & 32'h1);
    rd(fdi_pkg::OFS_CTRL, 32'h1, rv & 32'h1);
    apb(1'b1, fdi_pkg::OFS_CTRL, 32'h0);
    $display("test registers done");
    final_report();
  end
endmodule : fdi_drive_bench
